// ---- hcs_sequencer.sv ----
// Host command sequencer top: idle loop, dispatch and command routines.
// Assumes host inputs are synchronous to sys_clk_i and held while selected.
`timescale 1ns/1ps
module hcs_sequencer (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       host_select_n_i,
    input  wire logic [1:0] cmd_bank_i,
    input  wire logic [2:0] cmd_modifier_i,
    input  wire logic       host_write_n_i,
    output logic            ready_o,
    output logic            wcs_init_n_o,
    output logic            wcs_write_n_o,
    output logic            wcs_shift_clock_o,
    output logic            mop_shift_clock_o,
    output logic            diag_port_shift_clock_o,
    output logic            diag_mode_o,
    output logic            serial_source_select_o,
    output logic            cpu_bus_enable_n_o,
    output logic            host_buffer_enable_n_o,
    output logic            port_output_enable_n_o,
    output logic            mem_enable_n_o,
    output logic [3:0]      clock_command_o,
    output logic [5:0]      seq_location_o
);
    import hcs_pkg::*;

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        hcs_state_t  state;          // Current routine step
        logic [5:0]  loc;            // Program location shown out
        logic [15:0] word;           // Registered output word
        logic        zero_test_flag; // Branch test flag
    } hcs_regs_t;

    hcs_regs_t   regs_ff;      // Registered state
    hcs_regs_t   nxt_regs;     // Next state
    logic [15:0] nxt_word;     // Word of the next step
    logic [5:0]  target;       // First-branch target
    logic [3:0]  cmd_num;      // Second-branch command number
    logic        take_branch;  // Flag-tested branch condition

    // ****************************************
    // Branch target and word lookup
    // ****************************************
    hcs_dispatch u_dispatch (
        .host_select_n_i (host_select_n_i),
        .cmd_bank_i      (cmd_bank_i),
        .cmd_modifier_i  (cmd_modifier_i),
        .target_o        (target),
        .cmd_num_o       (cmd_num)
    );

    // Word follows the next state so outputs come from flops
    hcs_out_word u_out_word (
        .state_i (nxt_regs.state),
        .word_o  (nxt_word)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    // Flag is never set, so flag-zero branches always go
    always_comb
    begin
        take_branch             = ~regs_ff.zero_test_flag;
        nxt_regs                = regs_ff;
        nxt_regs.zero_test_flag = regs_ff.zero_test_flag;
        unique case (regs_ff.state)
            HCS_RESET:
            begin
                // Leave reset for the idle loop
                if (take_branch)
                begin
                    nxt_regs.state = HCS_IDLE;
                    nxt_regs.loc   = LOC_IDLE;
                end
            end
            HCS_IDLE:
            begin
                // Single-cycle loop until select drops
                if (take_branch)
                begin
                    nxt_regs.loc = target;
                    if (target[LOC_IDLE_BIT])
                    begin
                        // Deselected: bank bits are don't-care
                        nxt_regs.state = HCS_IDLE;
                    end
                    else
                    begin
                        // Selected: one of four entries
                        unique case (cmd_bank_i)
                            2'h0:    nxt_regs.state = HCS_MEM1;
                            2'h1:    nxt_regs.state = HCS_PORT1;
                            default: nxt_regs.state = HCS_COMDS;
                        endcase
                    end
                end
            end
            HCS_MEM1:
            begin
                // Data not valid yet, one more cycle
                nxt_regs.state = HCS_MEM2;
                nxt_regs.loc   = LOC_MEM2;
            end
            HCS_PORT1:
            begin
                // Read when write-not is high
                if (host_write_n_i)
                begin
                    nxt_regs.state = HCS_PORT_RD;
                    nxt_regs.loc   = LOC_PORT_RD;
                end
                else
                begin
                    nxt_regs.state = HCS_PORT_WR;
                    nxt_regs.loc   = LOC_PORT_WR;
                end
            end
            HCS_COMDS:
            begin
                // Second branch picks the routine
                if (take_branch)
                begin
                    nxt_regs.loc = LOC_CMD_BASE + {2'h0, cmd_num};
                    unique case (cmd_num)
                        CMD_HALT:     nxt_regs.state = HCS_HALT;
                        CMD_RUN:      nxt_regs.state = HCS_RUN;
                        CMD_STEP_ALL: nxt_regs.state = HCS_STEP_ALL;
                        CMD_STEP_CTL: nxt_regs.state = HCS_STEP_CTL;
                        default:
                        begin
                            // Unsupported commands just end the cycle
                            nxt_regs.state = HCS_HOST_ACK;
                            nxt_regs.loc   = LOC_HOST_ACK;
                        end
                    endcase
                end
            end
            HCS_STEP_ALL,
            HCS_STEP_CTL:
            begin
                // A step lasts one cycle; never repeat it
                if (take_branch)
                begin
                    nxt_regs.state = HCS_HOST_ACK;
                    nxt_regs.loc   = LOC_HOST_ACK;
                end
            end
            HCS_MEM2,
            HCS_PORT_WR,
            HCS_PORT_RD,
            HCS_HALT,
            HCS_RUN,
            HCS_HOST_ACK:
            begin
                // Hold ready until the host lets go
                if (host_select_n_i)
                begin
                    nxt_regs.state = HCS_IDLE;
                    nxt_regs.loc   = LOC_IDLE;
                end
            end
            default:
            begin
                // Illegal code: restart as after reset
                nxt_regs.state = HCS_RESET;
                nxt_regs.loc   = LOC_RESET;
            end
        endcase
        nxt_regs.word = nxt_word;
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset lands on location 63 with the reset word
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            regs_ff.state          <= HCS_RESET;
            regs_ff.loc            <= LOC_RESET;
            regs_ff.word           <= WORD_RESET;
            regs_ff.zero_test_flag <= 1'b0;
        end
        else
        begin
            regs_ff <= nxt_regs;
        end
    end

    // ****************************************
    // Output fan-out
    // ****************************************
    // Ready is active high; host waits while low
    assign ready_o                 = regs_ff.word[15];
    assign wcs_init_n_o            = regs_ff.word[14];
    assign wcs_write_n_o           = regs_ff.word[13];
    assign wcs_shift_clock_o       = regs_ff.word[12];
    assign mop_shift_clock_o       = regs_ff.word[11];
    assign diag_port_shift_clock_o = regs_ff.word[10];
    assign diag_mode_o             = regs_ff.word[9];
    assign serial_source_select_o  = regs_ff.word[8];
    assign cpu_bus_enable_n_o      = regs_ff.word[7];
    assign host_buffer_enable_n_o  = regs_ff.word[6];
    assign port_output_enable_n_o  = regs_ff.word[5];
    assign mem_enable_n_o          = regs_ff.word[4];
    assign clock_command_o         = regs_ff.word[3:0];
    assign seq_location_o          = regs_ff.loc;

    // ****************************************
    // Checks
    // ****************************************
    // Memory access: setup cycle then ready cycle
    sequence s_mem_setup;
        regs_ff.state == HCS_MEM1 && !ready_o && !mem_enable_n_o
            && !host_buffer_enable_n_o && cpu_bus_enable_n_o;
    endsequence

    sequence s_mem_ready;
        ready_o && !mem_enable_n_o && clock_command_o == CLK_HALT1;
    endsequence

    property p_reset_word;
        @(posedge sys_clk_i) rst_i |=> !ready_o && clock_command_o == CLK_HALT
            && seq_location_o == LOC_RESET;
    endproperty
    a_reset_word: assert property (p_reset_word) else $error("reset word wrong");

    property p_reset_to_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_RESET |=> regs_ff.state == HCS_IDLE;
    endproperty
    a_reset_to_idle: assert property (p_reset_to_idle) else $error("reset not left");

    property p_idle_wait;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_IDLE && host_select_n_i |=> regs_ff.state == HCS_IDLE
                && !ready_o && clock_command_o == CLK_NOP;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("idle loop broken");

    property p_dispatch;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_IDLE && !host_select_n_i && cmd_bank_i == 2'h1
                |=> regs_ff.state == HCS_PORT1 && seq_location_o == LOC_PORT1;
    endproperty
    a_dispatch: assert property (p_dispatch) else $error("dispatch target wrong");

    property p_mem_access;
        @(posedge sys_clk_i) disable iff (rst_i)
            s_mem_setup |=> s_mem_ready;
    endproperty
    a_mem_access: assert property (p_mem_access) else $error("memory access wrong");

    property p_port_branch;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_PORT1 && diag_mode_o && !serial_source_select_o
                |=> ready_o && diag_port_shift_clock_o
                    && (port_output_enable_n_o == $past(host_write_n_i, 1) ? 1'b0 : 1'b1) == 1'b1
                    && port_output_enable_n_o != $past(host_write_n_i, 1);
    endproperty
    a_port_branch: assert property (p_port_branch) else $error("port step wrong");

    property p_halt_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_HALT && !host_select_n_i |=> ready_o && clock_command_o == CLK_HALT;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt code dropped");

    property p_run_word;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_RUN |-> ready_o && clock_command_o == CLK_RUN;
    endproperty
    a_run_word: assert property (p_run_word) else $error("run code wrong");

    property p_step_once;
        @(posedge sys_clk_i) disable iff (rst_i)
            clock_command_o == CLK_STEP_ALL || clock_command_o == CLK_STEP_CTL
                |-> ready_o ##1 clock_command_o == CLK_NOP && ready_o;
    endproperty
    a_step_once: assert property (p_step_once) else $error("step repeated");

    property p_release;
        @(posedge sys_clk_i) disable iff (rst_i)
            ready_o && host_select_n_i && regs_ff.state != HCS_STEP_ALL
                && regs_ff.state != HCS_STEP_CTL |=> !ready_o && regs_ff.state == HCS_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("release not seen");

    property p_comds_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
            regs_ff.state == HCS_COMDS |-> regs_ff.word == WORD_IDLE ##1 ready_o;
    endproperty
    a_comds_idle: assert property (p_comds_idle) else $error("extended entry wrong");

endmodule

// ---- hcs_pkg.sv ----
// Constants, state codes and output words for the host command sequencer.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package hcs_pkg;

    // ****************************************
    // Sequencer states, one-hot
    // ****************************************
    typedef enum logic [12:0] {
        HCS_RESET    = 13'h0001,
        HCS_IDLE     = 13'h0002,
        HCS_MEM1     = 13'h0004,
        HCS_MEM2     = 13'h0008,
        HCS_PORT1    = 13'h0010,
        HCS_PORT_WR  = 13'h0020,
        HCS_PORT_RD  = 13'h0040,
        HCS_COMDS    = 13'h0080,
        HCS_HALT     = 13'h0100,
        HCS_RUN      = 13'h0200,
        HCS_STEP_ALL = 13'h0400,
        HCS_STEP_CTL = 13'h0800,
        HCS_HOST_ACK = 13'h1000
    } hcs_state_t;

    // ****************************************
    // Program locations
    // ****************************************
    localparam logic [5:0] LOC_RESET    = 6'h3f; // 63
    localparam logic [5:0] LOC_IDLE     = 6'h20; // 32
    localparam logic [5:0] LOC_MEM1     = 6'h00;
    localparam logic [5:0] LOC_MEM2     = 6'h01;
    localparam logic [5:0] LOC_PORT1    = 6'h08;
    localparam logic [5:0] LOC_PORT_WR  = 6'h09;
    localparam logic [5:0] LOC_PORT_RD  = 6'h0a;
    localparam logic [5:0] LOC_COMDS    = 6'h10;
    localparam logic [5:0] LOC_HOST_ACK = 6'h07;
    localparam logic [5:0] LOC_CMD_BASE = 6'h02; // Routine n sits at base+n, clear of the idle copies
    localparam int         LOC_IDLE_BIT = 5;     // Select line lands here

    // ****************************************
    // Clock command codes
    // ****************************************
    localparam logic [3:0] CLK_NOP      = 4'h0;
    localparam logic [3:0] CLK_HALT1    = 4'h1;
    localparam logic [3:0] CLK_HALT     = 4'h2;
    localparam logic [3:0] CLK_RUN      = 4'h3;
    localparam logic [3:0] CLK_STEP_ALL = 4'h4;
    localparam logic [3:0] CLK_STEP_CTL = 4'h6;

    // ****************************************
    // Extended command numbers
    // ****************************************
    localparam logic [3:0] CMD_HALT     = 4'h0;
    localparam logic [3:0] CMD_RUN      = 4'h1;
    localparam logic [3:0] CMD_STEP_ALL = 4'h2;
    localparam logic [3:0] CMD_STEP_CTL = 4'h3;

    // ****************************************
    // Output words, ready in bit 15, clock code in 3:0
    // ****************************************
    localparam int         W_READY = 15;
    localparam int         W_SHIFT = 10;
    localparam int         W_MODE  = 9;
    localparam int         W_SRCSEL = 8;
    localparam int         W_CPU_N = 7;
    localparam int         W_HOST_N = 6;
    localparam int         W_PORT_N = 5;
    localparam int         W_MEM_N = 4;
    localparam logic [15:0] WORD_RESET   = 16'h60f2;
    localparam logic [15:0] WORD_IDLE    = 16'h6070;
    localparam logic [15:0] WORD_MEM1    = 16'h60a1;
    localparam logic [15:0] WORD_MEM2    = 16'he0a1;
    localparam logic [15:0] WORD_PORT1   = 16'h62b1;
    localparam logic [15:0] WORD_PORT_WR = 16'he6b1;
    localparam logic [15:0] WORD_PORT_RD = 16'he691;
    localparam logic [15:0] WORD_HALT    = 16'he072;
    localparam logic [15:0] WORD_RUN     = 16'he073;
    localparam logic [15:0] WORD_STEP_A  = 16'he074;
    localparam logic [15:0] WORD_STEP_C  = 16'he076;
    localparam logic [15:0] WORD_ACK     = 16'he070;

endpackage

// ---- hcs_out_word.sv ----
// Output word lookup: one fixed word per sequencer state.
// Assumes the state input is a legal one-hot code.
`timescale 1ns/1ps
module hcs_out_word (
    input  wire hcs_pkg::hcs_state_t state_i,
    output logic [15:0]              word_o
);
    import hcs_pkg::*;

    // ****************************************
    // Word per state
    // ****************************************
    // Pure table, so every state shows the same word every time
    always_comb
    begin
        unique case (state_i)
            HCS_RESET:    word_o = WORD_RESET;
            HCS_IDLE:     word_o = WORD_IDLE;
            HCS_MEM1:     word_o = WORD_MEM1;
            HCS_MEM2:     word_o = WORD_MEM2;
            HCS_PORT1:    word_o = WORD_PORT1;
            HCS_PORT_WR:  word_o = WORD_PORT_WR;
            HCS_PORT_RD:  word_o = WORD_PORT_RD;
            HCS_COMDS:    word_o = WORD_IDLE;
            HCS_HALT:     word_o = WORD_HALT;
            HCS_RUN:      word_o = WORD_RUN;
            HCS_STEP_ALL: word_o = WORD_STEP_A;
            HCS_STEP_CTL: word_o = WORD_STEP_C;
            HCS_HOST_ACK: word_o = WORD_ACK;
            default:      word_o = WORD_IDLE;    // Illegal code: stay harmless
        endcase
    end
endmodule

// ---- hcs_dispatch.sv ----
// Multi-way branch targets formed from host select and address bits.
// Assumes the host holds these bits steady while selected.
`timescale 1ns/1ps
module hcs_dispatch (
    input  wire logic       host_select_n_i,
    input  wire logic [1:0] cmd_bank_i,
    input  wire logic [2:0] cmd_modifier_i,
    output logic [5:0]      target_o,
    output logic [3:0]      cmd_num_o
);
    import hcs_pkg::*;

    // ****************************************
    // First branch: select is the top bit
    // ****************************************
    // Eight targets; four deselected ones are idle copies
    always_comb
    begin
        target_o = {host_select_n_i, cmd_bank_i, 3'h0};
    end

    // ****************************************
    // Second branch: bank bit plus modifier
    // ****************************************
    always_comb
    begin
        cmd_num_o = {cmd_bank_i[0], cmd_modifier_i};
    end
endmodule

// ---- hcs_host_model.sv ----
// Host bus master model that drives the sequencer's select, address and direction lines.
// Assumes ready_i is the sequencer's registered, active-high ready output.
`timescale 1ns/1ps
module hcs_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic       ready_i,
    output logic            host_select_n_o,
    output logic [1:0]      cmd_bank_o,
    output logic [2:0]      cmd_modifier_o,
    output logic            host_write_n_o
);
    // ****************************************
    // Bus idle at start
    // ****************************************
    initial
    begin
        host_select_n_o = 1'b1;
        cmd_bank_o      = 2'h0;
        cmd_modifier_o  = 3'h0;
        host_write_n_o  = 1'b1;
    end

    // ****************************************
    // One transfer; hold_c slows the release
    // ****************************************
    task automatic xfer(input logic [1:0] b, input logic [2:0] m, input logic w, input int hold_c);
        int n;
        begin
            n = 0;
            @(posedge sys_clk_i);
            #1;
            cmd_bank_o      = b;
            cmd_modifier_o  = m;
            host_write_n_o  = w;
            host_select_n_o = 1'b0; // Held steady until ready
            @(posedge sys_clk_i);
            // Wait states while ready low; bounded so a dead board cannot hang us
            while (ready_i !== 1'b1 && n < 16)
            begin
                @(posedge sys_clk_i);
                n++;
            end
            repeat (hold_c) @(posedge sys_clk_i);
            #1;
            host_select_n_o = 1'b1; // Deselect ends it
            cmd_bank_o      = ~b;   // Released lines carry junk, never stale
            cmd_modifier_o  = ~m;
            host_write_n_o  = ~w;
            @(posedge sys_clk_i);
        end
    endtask
endmodule

// ---- tb_hcs_sequencer.sv ----
// Self-checking bench for the host command sequencer.
// Assumes hcs_pkg and the host model; outputs are compared as word plus location.
`timescale 1ns/1ps
module tb_hcs_sequencer;
    import hcs_pkg::*;
    logic        sys_clk_i;   // 125 MHz
    logic        rst_i;
    logic        host_select_n_i;
    logic [1:0]  cmd_bank_i;
    logic [2:0]  cmd_modifier_i;
    logic        host_write_n_i;
    logic        ready_o, wcs_init_n_o, wcs_write_n_o, wcs_shift_clock_o, mop_shift_clock_o;
    logic        diag_port_shift_clock_o, diag_mode_o, serial_source_select_o, cpu_bus_enable_n_o;
    logic        host_buffer_enable_n_o, port_output_enable_n_o, mem_enable_n_o;
    logic [3:0]  clock_command_o;
    logic [5:0]  seq_location_o;
    logic [21:0] notes[$];    // Expected word and location per step
    int          miscompares;
    int          n_checks;
    logic        mon_on;      // Monitor armed once idle

    hcs_sequencer hcs_sequencer_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .host_select_n_i(host_select_n_i), .cmd_bank_i(cmd_bank_i), .cmd_modifier_i(cmd_modifier_i),
        .host_write_n_i(host_write_n_i), .ready_o(ready_o), .wcs_init_n_o(wcs_init_n_o),
        .wcs_write_n_o(wcs_write_n_o), .wcs_shift_clock_o(wcs_shift_clock_o),
        .mop_shift_clock_o(mop_shift_clock_o), .diag_port_shift_clock_o(diag_port_shift_clock_o),
        .diag_mode_o(diag_mode_o), .serial_source_select_o(serial_source_select_o),
        .cpu_bus_enable_n_o(cpu_bus_enable_n_o), .host_buffer_enable_n_o(host_buffer_enable_n_o),
        .port_output_enable_n_o(port_output_enable_n_o), .mem_enable_n_o(mem_enable_n_o),
        .clock_command_o(clock_command_o), .seq_location_o(seq_location_o));

    hcs_host_model hcs_host_model_i (.sys_clk_i(sys_clk_i), .ready_i(ready_o),
        .host_select_n_o(host_select_n_i), .cmd_bank_o(cmd_bank_i),
        .cmd_modifier_o(cmd_modifier_i), .host_write_n_o(host_write_n_i));

    // ****************************************
    // Clock, helpers
    // ****************************************
    initial sys_clk_i = 1'b0;
    always #4 sys_clk_i = ~sys_clk_i;

    function automatic logic [21:0] outs();
        return {ready_o, wcs_init_n_o, wcs_write_n_o, wcs_shift_clock_o, mop_shift_clock_o,
                diag_port_shift_clock_o, diag_mode_o, serial_source_select_o, cpu_bus_enable_n_o,
                host_buffer_enable_n_o, port_output_enable_n_o, mem_enable_n_o, clock_command_o,
                seq_location_o};
    endfunction

    task automatic cmp(input string what, input logic [21:0] exp, input logic [21:0] got);
        begin
            n_checks++;
            if (got !== exp)
            begin
                miscompares++;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task automatic results();
        begin
            cmp("pending", 22'h0, 22'(notes.size())); // Every note consumed
            if (miscompares == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // ****************************************
    // Expected steps of one transfer
    // ****************************************
    task automatic run(input logic [1:0] b, input logic [2:0] m, input logic w, input int h);
        logic [21:0] fin;
        int          k;
        begin
            k = 2 + h; // Final step stands until the host lets go
            fin = {WORD_ACK, LOC_HOST_ACK}; // Unsupported command
            if (b == 2'h0)
            begin
                notes.push_back({WORD_MEM1, LOC_MEM1});
                fin = {WORD_MEM2, LOC_MEM2};
            end
            else if (b == 2'h1)
            begin
                notes.push_back({WORD_PORT1, LOC_PORT1});
                fin = w ? {WORD_PORT_RD, LOC_PORT_RD} : {WORD_PORT_WR, LOC_PORT_WR};
            end
            else
            begin
                notes.push_back({WORD_IDLE, LOC_COMDS | {b[0], 3'h0}});
                if ({b[0], m} == CMD_HALT)
                    fin = {WORD_HALT, LOC_CMD_BASE};
                else if ({b[0], m} == CMD_RUN)
                    fin = {WORD_RUN, LOC_CMD_BASE + 6'h1};
                else if ({b[0], m} == CMD_STEP_ALL || {b[0], m} == CMD_STEP_CTL)
                begin
                    // Step code lasts one cycle only, then the ack loop
                    notes.push_back(m[0] ? {WORD_STEP_C, LOC_CMD_BASE + 6'h3}
                                         : {WORD_STEP_A, LOC_CMD_BASE + 6'h2});
                    k--;
                end
            end
            repeat (k) notes.push_back(fin);
            hcs_host_model_i.xfer(b, m, w, h);
        end
    endtask

    // ****************************************
    // Monitor: each settled step against the oldest note
    // ****************************************
    always @(posedge sys_clk_i)
    begin
        #2;
        if (mon_on)
        begin
            // Four idle copies at 32, 40, 48 and 56; the junk bank bits left by the release pick which one
            if (seq_location_o[5] === 1'b1 && seq_location_o[2:0] === 3'h0)
                cmp("idle", {WORD_IDLE, LOC_IDLE | {1'b0, seq_location_o[4:3], 3'h0}}, outs());
            else if (notes.size() == 0)
                cmp("unexpected", 22'h0, outs());
            else
                cmp("step", notes.pop_front(), outs());
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'hc4594018));
        rst_i       = 1'b1;
        mon_on      = 1'b0;
        miscompares = 0;
        n_checks    = 0;
        repeat (8) @(posedge sys_clk_i);
        #1;
        cmp("reset", {WORD_RESET, LOC_RESET}, outs());
        rst_i = 1'b0;
        for (int i = 0; i < 4 && seq_location_o !== LOC_IDLE; i++) @(posedge sys_clk_i);
        mon_on = 1'b1;
        // Every bank, modifier and direction; slow host on some
        for (int b = 0; b < 4; b++)
            for (int m = 0; m < 8; m++)
                run(2'(b), 3'(m), m[1], m % 3);
        repeat (40)
            run(2'($urandom_range(3)), 3'($urandom_range(7)), 1'($urandom_range(1)), $urandom_range(3));
        repeat (4) @(posedge sys_clk_i);
        results();
    end

    // Watchdog: whole run is well under this
    initial
    begin
        #(8 * 20000);
        cmp("watchdog", 22'h0, 22'h1);
        results();
    end
endmodule
